// >>> design/sbp_port.sv
/*
 * Programming front end of a tuner synthesizer: two-wire slave and
 * three-wire shift port on shared pins, with divider and control latches.
 * Assumes the analogue address decoder presents the two address bits as
 * levels and that the lock detector presents a lock level.
 */
`default_nettype none

module sbp_port
   import sbp_pkg::*;
#(
   parameter int DIV_WIDTH = SBP_DIV_WIDTH,
   parameter int REF_RATIO = SBP_REF_RATIO
) (
   input  wire logic                 mclk,
   input  wire logic                 rst_n,
   input  wire logic                 scl_in,
   input  wire logic                 sda_in,
   output var  logic                 sda_out,
   output var  logic                 sda_oe_n,
   input  wire logic                 address_select_enable,
   input  wire logic                 address_bit_one,
   input  wire logic                 address_bit_two,
   input  wire logic                 lock_detect_in,
   input  wire logic                 ref_osc_in,
   output var  logic [DIV_WIDTH-1:0] divider_bits,
   output var  sbp_loop_t            loop_control,
   output var  sbp_switch_t          switch_out,
   output var  sbp_switch_t          switch_oe_n,
   output var  logic                 three_wire_mode,
   output var  logic                 ref_compare_pulse
);

   // ---------------------------------------------------------------
   // Pin synchronisation and edge detection
   // ---------------------------------------------------------------
   logic [SBP_PIN_COUNT-1:0] pins_raw;
   logic [SBP_PIN_COUNT-1:0] pins_sync;
   logic scl_s, sda_s, ena_s, ab1_s, ab2_s, lock_s;
   logic scl_prev_reg, sda_prev_reg, ena_prev_reg;
   logic [1:0] arm_cnt_reg;
   logic armed;
   logic scl_rise, scl_fall, ena_rise, ena_fall;
   logic start_cond, stop_cond, i2c_start;

   assign pins_raw[SBP_PIN_SCL]  = scl_in;
   assign pins_raw[SBP_PIN_SDA]  = sda_in;
   assign pins_raw[SBP_PIN_ENA]  = address_select_enable;
   assign pins_raw[SBP_PIN_AB1]  = address_bit_one;
   assign pins_raw[SBP_PIN_AB2]  = address_bit_two;
   assign pins_raw[SBP_PIN_LOCK] = lock_detect_in;
   assign pins_raw[SBP_PIN_REF]  = ref_osc_in;

   sbp_sync #(
      .WIDTH    (SBP_PIN_COUNT)
   ) u_sync (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .pin_in   (pins_raw),
      .pin_sync (pins_sync)
   );

   sbp_ref_div #(
      .RATIO         (REF_RATIO)
   ) u_ref_div (
      .mclk          (mclk),
      .rst_n         (rst_n),
      .ref_level     (pins_sync[SBP_PIN_REF]),
      .compare_pulse (ref_compare_pulse)
   );

   assign scl_s  = pins_sync[SBP_PIN_SCL];
   assign sda_s  = pins_sync[SBP_PIN_SDA];
   assign ena_s  = pins_sync[SBP_PIN_ENA];
   assign ab1_s  = pins_sync[SBP_PIN_AB1];
   assign ab2_s  = pins_sync[SBP_PIN_AB2];
   assign lock_s = pins_sync[SBP_PIN_LOCK];

   // Edges are held off until the synchroniser has filled, so a pin
   // resting high at power-up is not mistaken for an enable edge
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         arm_cnt_reg <= 2'h0;
      end else if (arm_cnt_reg != SBP_ARM_COUNT) begin
         arm_cnt_reg <= arm_cnt_reg + 2'h1;
      end
   end

   assign armed = (arm_cnt_reg == SBP_ARM_COUNT);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         scl_prev_reg <= 1'b0;
         sda_prev_reg <= 1'b0;
         ena_prev_reg <= 1'b0;
      end else begin
         scl_prev_reg <= scl_s;
         sda_prev_reg <= sda_s;
         ena_prev_reg <= ena_s;
      end
   end

   assign scl_rise   = armed & scl_s & ~scl_prev_reg;
   assign scl_fall   = armed & ~scl_s & scl_prev_reg;
   assign ena_rise   = armed & ena_s & ~ena_prev_reg;
   assign ena_fall   = armed & ~ena_s & ena_prev_reg;
   assign start_cond = armed & scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
   assign stop_cond  = armed & scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

   // A start seen inside an open three-wire enable window is just data
   assign i2c_start  = start_cond & ~(three_wire_mode & ena_s);

   // ---------------------------------------------------------------
   // Bus format detection
   // ---------------------------------------------------------------
   // The address pin is static in two-wire use, so a rising enable edge
   // means three-wire; a two-wire start takes the port back
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         three_wire_mode <= 1'b0;
      end else if (ena_rise) begin
         three_wire_mode <= 1'b1;
      end else if (i2c_start) begin
         three_wire_mode <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Two-wire slave
   // ---------------------------------------------------------------
   sbp_i2c_state_t state_reg;
   logic [3:0]     bit_cnt_reg;
   logic [7:0]     shift_reg;
   logic           ack_reg;
   logic [7:0]     own_address;
   logic           addr_match;
   logic           byte_commit;

   // Address bits come from the address pin decoder in this mode
   assign own_address = {SBP_ADDR_FIXED, ab1_s, ab2_s, SBP_WRITE_BIT};
   assign addr_match  = (shift_reg == own_address);
   assign byte_commit = (state_reg == SBP_DACK) & scl_fall;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg   <= SBP_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg   <= 8'h00;
         ack_reg     <= 1'b0;
      end else if (stop_cond || (three_wire_mode && !i2c_start)) begin
         state_reg <= SBP_IDLE;
         ack_reg   <= 1'b0;
      end else if (i2c_start) begin
         state_reg   <= SBP_ADDR;
         bit_cnt_reg <= 4'h0;
         ack_reg     <= 1'b0;
      end else begin
         case (state_reg)
            SBP_ADDR, SBP_DATA: begin
               if (scl_rise && bit_cnt_reg != SBP_BYTE_BITS) begin
                  shift_reg   <= {shift_reg[6:0], sda_s};
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (scl_fall && bit_cnt_reg == SBP_BYTE_BITS) begin
                  if (state_reg == SBP_DATA) begin
                     state_reg <= SBP_DACK;
                     ack_reg   <= 1'b1;
                  end else if (addr_match) begin
                     state_reg <= SBP_AACK;
                     ack_reg   <= 1'b1;
                  end else begin
                     state_reg <= SBP_IDLE;
                  end
               end
            end
            SBP_AACK, SBP_DACK: begin
               if (scl_fall) begin
                  state_reg   <= SBP_DATA;
                  bit_cnt_reg <= 4'h0;
                  ack_reg     <= 1'b0;
               end
            end
            default: begin
               ack_reg <= 1'b0;
            end
         endcase
      end
   end

   // Open-drain data line: only ever pulled low
   assign sda_out  = 1'b0;
   assign sda_oe_n = ~ack_reg;

   // ---------------------------------------------------------------
   // Data byte pairing
   // ---------------------------------------------------------------
   logic       pair_second_reg;
   logic       pair_ctrl_reg;
   logic [6:0] div_high_reg;
   sbp_loop_t  loop_reg;
   logic       tw_latch;
   logic [18:0] tw_shift_reg;
   logic [4:0] tw_cnt_reg;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pair_second_reg <= 1'b0;
         pair_ctrl_reg   <= 1'b0;
         div_high_reg    <= 7'h00;
         loop_reg        <= SBP_LOOP_RESET;
      end else if (i2c_start) begin
         pair_second_reg <= 1'b0;
      end else if (byte_commit) begin
         pair_second_reg <= ~pair_second_reg;
         if (!pair_second_reg) begin
            pair_ctrl_reg <= shift_reg[SBP_BYTE_MSB];
            if (!shift_reg[SBP_BYTE_MSB]) begin
               div_high_reg <= shift_reg[SBP_DIV_HI_MSB:0];
            end else begin
               // Unused bits 3..1 are dropped
               loop_reg.pump_current_high  <= shift_reg[SBP_LCB_PCH];
               loop_reg.divider_test       <= shift_reg[SBP_LCB_DT];
               loop_reg.charge_pump_off    <= shift_reg[SBP_LCB_CPO];
               loop_reg.varicap_driver_off <= shift_reg[SBP_LCB_VDO];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Three-wire shift port
   // ---------------------------------------------------------------
   // Counter saturates so that a long burst can never wrap back to 19
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tw_shift_reg <= 19'h00000;
         tw_cnt_reg   <= 5'h00;
      end else if (ena_rise) begin
         tw_cnt_reg <= 5'h00;
      end else if (three_wire_mode && ena_s && scl_fall) begin
         tw_shift_reg <= {tw_shift_reg[17:0], sda_s};
         if (tw_cnt_reg != 5'h1f) begin
            tw_cnt_reg <= tw_cnt_reg + 5'h01;
         end
      end
   end

   assign tw_latch = three_wire_mode & ena_fall & (tw_cnt_reg == SBP_TW_BITS);

   // ---------------------------------------------------------------
   // Divider and switch latches
   // ---------------------------------------------------------------
   sbp_switch_t switch_reg;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         divider_bits <= SBP_DIV_RESET;
         switch_reg   <= SBP_SWITCH_RESET;
      end else if (tw_latch) begin
         divider_bits     <= tw_shift_reg[DIV_WIDTH-1:0];
         switch_reg.seven <= tw_shift_reg[SBP_TW_S7];
         switch_reg.six   <= tw_shift_reg[SBP_TW_S6];
         switch_reg.five  <= tw_shift_reg[SBP_TW_S5];
         switch_reg.four  <= tw_shift_reg[SBP_TW_S4];
      end else if (byte_commit && pair_second_reg) begin
         if (!pair_ctrl_reg) begin
            // Plain binary ratio, applied as one whole value
            divider_bits <= {div_high_reg, shift_reg};
         end else begin
            switch_reg.seven <= shift_reg[SBP_SWB_S7];
            switch_reg.six   <= shift_reg[SBP_SWB_S6];
            switch_reg.five  <= shift_reg[SBP_SWB_S5];
            switch_reg.four  <= shift_reg[SBP_SWB_S4];
            switch_reg.one   <= shift_reg[SBP_SWB_S1];
         end
      end
   end

   // ---------------------------------------------------------------
   // Output stage
   // ---------------------------------------------------------------
   // Registered so the analogue side never sees a decode glitch
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         loop_control <= SBP_LOOP_RESET;
      end else begin
         loop_control <= loop_reg;
         loop_control.pump_current_high <=
            three_wire_mode | loop_reg.pump_current_high;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         switch_oe_n <= '{default: 1'b1};
      end else begin
         switch_oe_n.seven <= ~switch_reg.seven;
         switch_oe_n.six   <= ~switch_reg.six;
         switch_oe_n.five  <= ~switch_reg.five;
         switch_oe_n.four  <= ~switch_reg.four;
         switch_oe_n.one   <= three_wire_mode ? ~lock_s
                                              : ~switch_reg.one;
      end
   end

   // Open-collector outputs only ever sink
   assign switch_out = SBP_SWITCH_RESET;

endmodule

`default_nettype wire

// >>> design/sbp_pkg.sv
/*
 * Shared constants and types of the synthesizer programming port.
 * Assumes a single system clock; every pin input is synchronised first.
 */
`default_nettype none

package sbp_pkg;

   // ---------------------------------------------------------------
   // Pin vector layout after synchronisation
   // ---------------------------------------------------------------
   localparam int SBP_PIN_COUNT = 7;
   localparam int SBP_PIN_SCL   = 0;
   localparam int SBP_PIN_SDA   = 1;
   localparam int SBP_PIN_ENA   = 2;
   localparam int SBP_PIN_AB1   = 3;
   localparam int SBP_PIN_AB2   = 4;
   localparam int SBP_PIN_LOCK  = 5;
   localparam int SBP_PIN_REF   = 6;

   // ---------------------------------------------------------------
   // Two-wire framing
   // ---------------------------------------------------------------
   localparam logic [4:0] SBP_ADDR_FIXED = 5'h18;
   localparam logic       SBP_WRITE_BIT  = 1'h0;
   localparam logic [3:0] SBP_BYTE_BITS  = 4'h8;
   localparam int         SBP_BYTE_MSB   = 7;
   localparam int         SBP_DIV_HI_MSB = 6;

   // Loop control byte fields
   localparam int SBP_LCB_PCH = 6;
   localparam int SBP_LCB_DT  = 5;
   localparam int SBP_LCB_CPO = 4;
   localparam int SBP_LCB_VDO = 0;

   // Switch byte fields
   localparam int SBP_SWB_S7  = 7;
   localparam int SBP_SWB_S6  = 6;
   localparam int SBP_SWB_S5  = 5;
   localparam int SBP_SWB_S4  = 4;
   localparam int SBP_SWB_S1  = 1;

   // ---------------------------------------------------------------
   // Divider and three-wire word
   // ---------------------------------------------------------------
   localparam int         SBP_DIV_WIDTH = 15;
   localparam logic [4:0] SBP_TW_BITS   = 5'h13;
   localparam int         SBP_TW_S7     = 18;
   localparam int         SBP_TW_S6     = 17;
   localparam int         SBP_TW_S5     = 16;
   localparam int         SBP_TW_S4     = 15;
   localparam int         SBP_REF_RATIO = 512;
   localparam logic [1:0] SBP_ARM_COUNT = 2'h3;

   localparam logic [SBP_DIV_WIDTH-1:0] SBP_DIV_RESET = 15'h0000;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic pump_current_high;
      logic divider_test;
      logic charge_pump_off;
      logic varicap_driver_off;
   } sbp_loop_t;

   typedef struct packed {
      logic seven;
      logic six;
      logic five;
      logic four;
      logic one;
   } sbp_switch_t;

   typedef enum logic [2:0] {
      SBP_IDLE = 3'b000,
      SBP_ADDR = 3'b001,
      SBP_AACK = 3'b010,
      SBP_DATA = 3'b011,
      SBP_DACK = 3'b100
   } sbp_i2c_state_t;

   localparam sbp_loop_t   SBP_LOOP_RESET   = '{default: 1'b0};
   localparam sbp_switch_t SBP_SWITCH_RESET = '{default: 1'b0};

endpackage

`default_nettype wire

// >>> design/sbp_sync.sv
/*
 * Two flip-flop synchroniser for a vector of unrelated pin levels.
 * Assumes each bit is a slow level; no bus coherence between bits.
 */
`default_nettype none

module sbp_sync
   import sbp_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input  wire logic             mclk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] pin_in,
   output var  logic [WIDTH-1:0] pin_sync
);

   logic [WIDTH-1:0] meta_reg;

   // First stage is read only by the second
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         pin_sync <= '0;
      end else begin
         meta_reg <= pin_in;
         pin_sync <= meta_reg;
      end
   end

endmodule

`default_nettype wire

// >>> design/sbp_ref_div.sv
/*
 * Fixed reference divider: counts rising edges of the sampled reference
 * oscillator and emits one comparison pulse per RATIO edges.
 * Assumes the reference is already synchronised and well below mclk/2.
 */
`default_nettype none

module sbp_ref_div
   import sbp_pkg::*;
#(
   parameter int RATIO = SBP_REF_RATIO
) (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic ref_level,
   output var  logic compare_pulse
);

   localparam int CW = $clog2(RATIO);
   localparam logic [CW-1:0] LAST = CW'(RATIO - 1);

   logic          ref_prev_reg;
   logic [CW-1:0] count_reg;
   logic          ref_rise;

   assign ref_rise = ref_level & ~ref_prev_reg;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ref_prev_reg  <= 1'b0;
         count_reg     <= '0;
         compare_pulse <= 1'b0;
      end else begin
         ref_prev_reg  <= ref_level;
         compare_pulse <= ref_rise && (count_reg == LAST);
         if (ref_rise) begin
            count_reg <= (count_reg == LAST) ? '0 : count_reg + 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// >>> tb/sbp_port_properties.sv
/* Concurrent checks on the programming port, bound onto sbp_port.
   Assumes only the top module's ports are visible. */
`default_nettype none

module sbp_port_properties
   import sbp_pkg::*;
#(
   parameter int DIV_WIDTH = SBP_DIV_WIDTH
) (
   input wire logic                 mclk,
   input wire logic                 rst_n,
   input wire logic                 scl_in,
   input wire logic                 address_select_enable,
   input wire logic                 lock_detect_in,
   input wire logic                 sda_oe_n,
   input wire logic [DIV_WIDTH-1:0] divider_bits,
   input wire sbp_loop_t            loop_control,
   input wire sbp_switch_t          switch_oe_n,
   input wire logic                 three_wire_mode,
   input wire logic                 ref_compare_pulse
);
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   // ------------------------------------------------------------
   // Acknowledge slot
   // ------------------------------------------------------------
   sequence ack_start_s;
      $fell(sda_oe_n);
   endsequence
   sequence ack_end_s;
      !sda_oe_n && $fell(scl_in);
   endsequence

   ack_hold_a: assert property (
      ack_start_s |-> !scl_in ##1 (!sda_oe_n)[*8])
      else $error("ack not held");
   ack_release_a: assert property (
      ack_end_s |-> ##[1:6] sda_oe_n)
      else $error("ack not released");
   no_tw_ack_a: assert property (
      !sda_oe_n |-> !three_wire_mode)
      else $error("ack in three-wire mode");

   // ------------------------------------------------------------
   // Latches and mode
   // ------------------------------------------------------------
   sequence locked_s;
      (three_wire_mode && lock_detect_in)[*6];
   endsequence
   sequence unlocked_s;
      (three_wire_mode && !lock_detect_in)[*6];
   endsequence

   pump_forced_a: assert property (
      three_wire_mode && $past(three_wire_mode, 2)
      |-> loop_control.pump_current_high) else $error("pump not high");
   lock_on_a: assert property (
      locked_s |-> !switch_oe_n.one) else $error("lock not shown");
   lock_off_a: assert property (
      unlocked_s |-> switch_oe_n.one) else $error("unlock not shown");
   div_quiet_a: assert property (
      $changed(divider_bits)
      |-> !scl_in && !(three_wire_mode && address_select_enable))
      else $error("divider changed mid transfer");
   sw_quiet_a: assert property (
      $changed(switch_oe_n[4:1]) |-> !scl_in)
      else $error("switch changed mid bit");
   mode_enter_a: assert property (
      $rose(three_wire_mode) |-> address_select_enable)
      else $error("mode entered without enable");
   mode_leave_a: assert property (
      $fell(three_wire_mode) |-> !address_select_enable)
      else $error("mode left with enable high");
   ref_pulse_a: assert property (
      ref_compare_pulse |=> (!ref_compare_pulse)[*3])
      else $error("compare pulse too long");
endmodule

bind sbp_port sbp_port_properties #(.DIV_WIDTH(DIV_WIDTH)) u_props (
   .mclk(mclk), .rst_n(rst_n), .scl_in(scl_in),
   .address_select_enable(address_select_enable),
   .lock_detect_in(lock_detect_in), .sda_oe_n(sda_oe_n),
   .divider_bits(divider_bits), .loop_control(loop_control),
   .switch_oe_n(switch_oe_n), .three_wire_mode(three_wire_mode),
   .ref_compare_pulse(ref_compare_pulse)
);

`default_nettype wire

// >>> tb/sbp_host.sv
/* Host bus master: two-wire writes and three-wire words.
   Assumes the bench resolves the open-drain data line with a pull-up. */
`default_nettype none

module sbp_host (
   input  wire logic mclk,
   input  wire logic sda_line,
   output var  logic scl,
   output var  logic sda,
   output var  logic ena
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      scl = 1'h1;
      sda = 1'h1;
      ena = 1'h0;
   end

   task automatic w(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // ------------------------------------------------------------
   // Two-wire; 25 mclk a bit; data moves 2 mclk after a clock fall
   // so the port never sees a false start or stop
   // ------------------------------------------------------------
   task automatic start();
      w(2);
      sda = 1'h1;
      w(10);
      scl = 1'h1;
      w(13);
      sda = 1'h0;
      w(13);
      scl = 1'h0;
   endtask

   task automatic stop();
      w(2);
      sda = 1'h0;
      w(10);
      scl = 1'h1;
      w(13);
      sda = 1'h1;
      w(13);
   endtask

   task automatic bit_out(input logic b);
      w(2);
      sda = b;
      w(10);
      scl = 1'h1;
      w(13);
      scl = 1'h0;
   endtask

   task automatic put(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) bit_out(b[i]);
      w(2);
      sda = 1'h1;
      w(10);
      scl = 1'h1;
      w(6);
      ack = ~sda_line;
      w(7);
      scl = 1'h0;
   endtask

   // Three-wire word, first bit first; n clocks while enable is high
   task automatic tw(input logic [18:0] word, input int n);
      scl = 1'h0;
      w(12);
      ena = 1'h1;
      w(13);
      for (int i = 0; i < n; i++) begin
         sda = (i < 19) ? word[18 - i] : 1'h0;
         w(6);
         scl = 1'h1;
         w(12);
         scl = 1'h0;
         w(7);
      end
      ena = 1'h0;
      w(13);
   endtask
endmodule

`default_nettype wire

// >>> tb/sbp_port_test.sv
/* Self-checking bench for the synthesizer programming port.
   Assumes the host model and the bound checker are compiled first. */
`default_nettype none

module sbp_port_test
   import sbp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic                     mclk = 1'h0;
   logic                     rst_n = 1'h0;
   logic                     scl;
   logic                     sda;
   logic                     ena;
   wire logic                sda_line;
   logic                     sda_out;
   logic                     sda_oe_n;
   logic                     address_bit_one = 1'h0;
   logic                     address_bit_two = 1'h0;
   logic                     lock_detect_in = 1'h0;
   logic                     ref_osc_in = 1'h0;
   logic [SBP_DIV_WIDTH-1:0] divider_bits;
   sbp_loop_t                loop_control;
   sbp_switch_t              switch_out;
   sbp_switch_t              switch_oe_n;
   logic                     three_wire_mode;
   logic                     ref_compare_pulse;
   int                       n_errors = 0;
   int                       total_checks = 0;
   logic [14:0] dv_tab [4] = '{15'h7fff, 15'h0001, 15'h4000, 15'h1234};
   logic [7:0]  c1_tab [4] = '{8'hc1, 8'hb0, 8'hf1, 8'h81};
   logic [7:0]  c2_tab [4] = '{8'hf2, 8'h50, 8'h00, 8'ha2};

   assign sda_line = sda & (sda_oe_n | sda_out);
   always #2.5 mclk = ~mclk;
   always begin
      repeat (5) @(negedge mclk);
      ref_osc_in = ~ref_osc_in;
   end

   sbp_host u_sbp_host (
      .mclk(mclk), .sda_line(sda_line), .scl(scl), .sda(sda), .ena(ena)
   );
   sbp_port #(.REF_RATIO(8)) u_sbp_port (
      .mclk(mclk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .address_select_enable(ena), .address_bit_one(address_bit_one),
      .address_bit_two(address_bit_two), .lock_detect_in(lock_detect_in),
      .ref_osc_in(ref_osc_in), .divider_bits(divider_bits),
      .loop_control(loop_control), .switch_out(switch_out),
      .switch_oe_n(switch_oe_n), .three_wire_mode(three_wire_mode),
      .ref_compare_pulse(ref_compare_pulse)
   );

   task automatic w(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task automatic chk(input logic [18:0] got, input logic [18:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic send(input logic [7:0] b, input logic exp_ack);
      logic a;
      u_sbp_host.put(b, a);
      chk(19'(a), 19'(exp_ack));
   endtask

   task automatic conclude();
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      chk(19'(divider_bits), 19'h0);
      chk(19'(loop_control), 19'h0);
      chk(19'(switch_oe_n), 19'h1f);
      chk(19'({three_wire_mode, sda_oe_n}), 19'h1);
      chk(19'({switch_out, sda_out}), 19'h0);
   endtask

   // Odd k sends the control pair first, even k the divider pair first
   task automatic t_program(input int k);
      logic [14:0] dv;
      logic [14:0] old;
      logic [3:0]  lp;
      logic [4:0]  sw;
      dv = dv_tab[k];
      old = divider_bits;
      lp = {c1_tab[k][6:4], c1_tab[k][0]};
      sw = ~{c2_tab[k][7:4], c2_tab[k][1]};
      address_bit_one = k[1];
      address_bit_two = k[0];
      w(8);
      u_sbp_host.start();
      send({5'h18, k[1], k[0], 1'h0}, 1'h1);
      if (k[0]) begin
         send(c1_tab[k], 1'h1);
         send(c2_tab[k], 1'h1);
      end
      send({1'h0, dv[14:8]}, 1'h1);
      chk(19'(divider_bits), 19'(old));
      send(dv[7:0], 1'h1);
      if (!k[0]) begin
         send(c1_tab[k], 1'h1);
         send(c2_tab[k], 1'h1);
      end
      u_sbp_host.stop();
      chk(19'(divider_bits), 19'(dv));
      chk(19'(loop_control), 19'(lp));
      chk(19'(switch_oe_n), 19'(sw));
   endtask

   task automatic t_reject();
      logic [14:0] old;
      old = divider_bits;
      address_bit_one = 1'h0;
      address_bit_two = 1'h0;
      w(8);
      u_sbp_host.start();
      send(8'hc0, 1'h1);
      send(8'h15, 1'h1);
      u_sbp_host.stop();
      u_sbp_host.start();
      send(8'hc2, 1'h0);
      send(8'h00, 1'h0);
      u_sbp_host.start();
      send(8'hc1, 1'h0);
      u_sbp_host.stop();
      chk(19'(divider_bits), 19'(old));
   endtask

   task automatic t_three();
      lock_detect_in = 1'h1;
      u_sbp_host.tw({4'ha, 15'h2b3c}, 19);
      w(6);
      chk(19'(three_wire_mode), 19'h1);
      chk(19'(divider_bits), 19'h2b3c);
      chk(19'(switch_oe_n), 19'h0a);
      chk(19'(loop_control.pump_current_high), 19'h1);
      lock_detect_in = 1'h0;
      w(6);
      chk(19'(switch_oe_n.one), 19'h1);
      u_sbp_host.tw(19'h7ffff, 18);
      u_sbp_host.tw(19'h7ffff, 20);
      repeat (19) u_sbp_host.bit_out(1'h1);
      w(6);
      chk(19'(divider_bits), 19'h2b3c);
   endtask

   // The stored pump bit was 0, so it must resurface here
   task automatic t_back();
      u_sbp_host.start();
      send(8'hc0, 1'h1);
      u_sbp_host.stop();
      chk(19'(three_wire_mode), 19'h0);
      chk(19'(loop_control.pump_current_high), 19'h0);
   endtask

   // Reference toggles every 5 mclk: 8 edges are 80 mclk apart
   task automatic t_ref();
      int n;
      repeat (200) if (!ref_compare_pulse) @(negedge mclk);
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (!ref_compare_pulse && n < 300);
      chk(19'(n), 19'h50);
   endtask

   initial begin
      w(10);
      rst_n = 1'h1;
      w(8);
      t_reset();
      for (int k = 0; k < 4; k++) t_program(k);
      t_reject();
      t_three();
      t_back();
      t_ref();
      conclude();
   end

   // Tests take about 44 us; over five times that means a hang
   initial begin
      #250000;
      n_errors++;
      conclude();
   end
endmodule

`default_nettype wire
